//--- design/oss_selector.sv
`timescale 1ns/100ps
`default_nettype none

module oss_selector #(
    parameter int NUM_TERM      = 6,
    parameter int STEPS_PER_REV = oss_pkg::STEPS_PER_REV,
    parameter int IDX_W         = 3
) (
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire oss_pkg::oss_status_t                status_in,
    input  wire logic signed [oss_pkg::POS_W-1:0]    position,
    input  wire logic        [oss_pkg::SPD_W-1:0]    speed_now,
    input  wire logic        [oss_pkg::SPD_W-1:0]    speed_target,
    input  wire logic signed [oss_pkg::POS_W-1:0]    fw_limit,
    input  wire logic signed [oss_pkg::POS_W-1:0]    rv_limit,
    input  wire logic signed [oss_pkg::POS_W-1:0]    wrap_home,
    input  wire oss_pkg::oss_window_t                data_zone,
    input  wire oss_pkg::oss_window_t [7:0]          zones,
    input  wire logic                                cfg_we,
    input  wire logic        [IDX_W-1:0]             cfg_idx,
    input  wire logic        [oss_pkg::CODE_W-1:0]   cfg_code,
    output logic [NUM_TERM-1:0][oss_pkg::CODE_W-1:0] term_code,
    output logic [NUM_TERM-1:0]                      term_out,
    output logic                                     wrap_overflow_toggle
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_TERM-1:0][oss_pkg::CODE_W-1:0] code;
        logic [NUM_TERM-1:0]                      out;
        logic                                     eto_latch;
        logic                                     home_end;
        logic                                     wrap_tog;
    } oss_sel_state_t;

    oss_sel_state_t st_ff;
    oss_sel_state_t nxt_st;

    // ------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------
    logic       sto1_off;
    logic       sto2_off;
    logic       both_torque_off_monitor;
    logic       any_torque_off_monitor;
    logic       speed_reached_out;
    logic       forward_soft_limit_out;
    logic       reverse_soft_limit_out;
    logic       wrap_origin_out;
    logic       once_per_rev_out;
    logic       shaft_angle_tick_out;
    logic [8:0] zone_hit;

    assign sto1_off = !status_in.safe_torque_off_input_1;
    assign sto2_off = !status_in.safe_torque_off_input_2;
    assign both_torque_off_monitor = sto1_off && sto2_off;
    assign any_torque_off_monitor  = sto1_off || sto2_off;
    assign speed_reached_out = (speed_now == speed_target);
    assign forward_soft_limit_out = (position >= fw_limit);
    assign reverse_soft_limit_out = (position <= rv_limit);
    assign wrap_origin_out = status_in.wrap_enable
                             && (position == wrap_home);

    // Both counters restart at the preset point
    oss_rev_counter #(
        .MODULUS (STEPS_PER_REV)
    ) u_rev (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clear     (status_in.preset_exec),
        .step_fwd  (status_in.step_fwd),
        .step_rev  (status_in.step_rev),
        .at_origin (once_per_rev_out)
    );

    // Fractional steps per tick are truncated
    oss_rev_counter #(
        .MODULUS (STEPS_PER_REV / oss_pkg::TICKS_PER_REV)
    ) u_tick (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clear     (status_in.preset_exec),
        .step_fwd  (status_in.step_fwd),
        .step_rev  (status_in.step_rev),
        .at_origin (shaft_angle_tick_out)
    );

    // Index 0 is the operation-data zone, 1..8 the fixed zones
    genvar gz;
    generate
        for (gz = 0; gz < 9; gz++) begin : g_zone
            oss_pkg::oss_window_t win;
            if (gz == 0) begin : g_data
                assign win = data_zone;
            end else begin : g_fixed
                assign win = zones[gz-1];
            end
            oss_window_cmp #(
                .POS_W (oss_pkg::POS_W)
            ) u_win (
                .position (position),
                .lo       (win.lo),
                .hi       (win.hi),
                .in_zone  (zone_hit[gz])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------
    function automatic logic decode(
        input logic [oss_pkg::CODE_W-1:0] code,
        input oss_sel_state_t             st
    );
        logic r;
        r = 1'b0;
        if ((code >= oss_pkg::CODE_ZONE_0)
            && (code <= oss_pkg::CODE_ZONE_7)) begin
            r = zone_hit[code[2:0] + 4'h1];
        end else begin
            case (code)
                oss_pkg::CODE_CONST_OFF:    r = 1'b0;
                oss_pkg::CODE_ALARM_NO:     r = status_in.alarm;
                oss_pkg::CODE_ALARM_NC:     r = !status_in.alarm;
                oss_pkg::CODE_READY:        r = status_in.ready;
                oss_pkg::CODE_PULSE_EN:     r = status_in.pulse_in_en;
                oss_pkg::CODE_TORQUE_REC:   r = st.eto_latch;
                oss_pkg::CODE_POS_DONE:     r = status_in.pos_done;
                oss_pkg::CODE_SPEED_REACH:  r = speed_reached_out;
                oss_pkg::CODE_EXCITATION:   r = status_in.excited;
                oss_pkg::CODE_HOME_DONE:    r = st.home_end;
                oss_pkg::CODE_REPRESET:
                    r = status_in.preset_invalid;
                oss_pkg::CODE_WRAP_OVF:     r = st.wrap_tog;
                oss_pkg::CODE_FW_SOFT_LIM:  r = forward_soft_limit_out;
                oss_pkg::CODE_RV_SOFT_LIM:  r = reverse_soft_limit_out;
                oss_pkg::CODE_ONCE_PER_REV: r = once_per_rev_out;
                oss_pkg::CODE_WRAP_ORIGIN:  r = wrap_origin_out;
                oss_pkg::CODE_ANGLE_TICK:   r = shaft_angle_tick_out;
                oss_pkg::CODE_DATA_ZONE:    r = zone_hit[0];
                oss_pkg::CODE_BRAKE_REL:
                    r = status_in.brake_released;
                oss_pkg::CODE_BOTH_STO:     r = both_torque_off_monitor;
                oss_pkg::CODE_ANY_STO:      r = any_torque_off_monitor;
                oss_pkg::CODE_POS_REPORT:
                    r = status_in.pos_report_bit;
                oss_pkg::CODE_PULSE_REQ:
                    r = status_in.pulse_req_prep_done;
                // Unlisted codes behave as always-off
                default:                    r = 1'b0;
            endcase
        end
        return r;
    endfunction : decode

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (cfg_we && (int'(cfg_idx) == i)) begin
                nxt_st.code[i] = cfg_code;
            end
            nxt_st.out[i] = decode(st_ff.code[i], st_ff);
        end
        // Set while torque is off wins over the excitation clear
        nxt_st.eto_latch = any_torque_off_monitor
                           || (st_ff.eto_latch && !status_in.excited);
        // Completion latches; lost preset clears it, new completion wins
        nxt_st.home_end = status_in.hs_home_done || status_in.home_done
                          || status_in.preset_exec
                          || (st_ff.home_end
                              && !status_in.preset_invalid);
        if (status_in.wrap_exceed) begin
            nxt_st.wrap_tog = !st_ff.wrap_tog;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{code:      {NUM_TERM{oss_pkg::CODE_RESET}},
                       out:       '0,
                       eto_latch: 1'b0,
                       home_end:  1'b0,
                       wrap_tog:  1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign term_code            = st_ff.code;
    assign term_out             = st_ff.out;
    assign wrap_overflow_toggle = st_ff.wrap_tog;

    // ------------------------------------------------------------
    // Checks on terminal 0 and on the shared latches
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_const_off;
        st_ff.code[0] == oss_pkg::CODE_CONST_OFF |=> !term_out[0];
    endproperty
    a_const_off: assert property (p_const_off)
        else $error("always-off terminal went on");

    property p_alarm_no;
        st_ff.code[0] == oss_pkg::CODE_ALARM_NO
            |=> term_out[0] == $past(status_in.alarm);
    endproperty
    a_alarm_no: assert property (p_alarm_no)
        else $error("open alarm output wrong");

    property p_alarm_nc;
        st_ff.code[0] == oss_pkg::CODE_ALARM_NC && status_in.alarm
            |=> !term_out[0];
    endproperty
    a_alarm_nc: assert property (p_alarm_nc)
        else $error("closed alarm output stayed on");

    property p_torque_rec;
        (st_ff.code[0] == oss_pkg::CODE_TORQUE_REC && sto1_off)
            ##1 (st_ff.code[0] == oss_pkg::CODE_TORQUE_REC)
            |=> term_out[0];
    endproperty
    a_torque_rec: assert property (p_torque_rec)
        else $error("torque-off recovery output missing");

    property p_torque_hold;
        st_ff.eto_latch && !status_in.excited |=> st_ff.eto_latch;
    endproperty
    a_torque_hold: assert property (p_torque_hold)
        else $error("recovery latch dropped before excitation");

    property p_home_end;
        status_in.preset_exec |=> st_ff.home_end;
    endproperty
    a_home_end: assert property (p_home_end)
        else $error("preset did not flag homing done");

    property p_wrap_tog;
        status_in.wrap_exceed |=> wrap_overflow_toggle
                                  != $past(wrap_overflow_toggle);
    endproperty
    a_wrap_tog: assert property (p_wrap_tog)
        else $error("wrap overflow did not toggle");

    property p_both_sto;
        st_ff.code[0] == oss_pkg::CODE_BOTH_STO
            |=> term_out[0] == $past(sto1_off && sto2_off);
    endproperty
    a_both_sto: assert property (p_both_sto)
        else $error("both torque-off monitor wrong");

    property p_any_sto;
        st_ff.code[0] == oss_pkg::CODE_ANY_STO
            |=> term_out[0] == $past(sto1_off || sto2_off);
    endproperty
    a_any_sto: assert property (p_any_sto)
        else $error("any torque-off monitor wrong");

    property p_speed;
        st_ff.code[0] == oss_pkg::CODE_SPEED_REACH
            |=> term_out[0] == $past(speed_now == speed_target);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed reached output wrong");

    property p_unlisted;
        st_ff.code[0] == 8'h83 || st_ff.code[0] == 8'hb2
            |=> !term_out[0];
    endproperty
    a_unlisted: assert property (p_unlisted)
        else $error("unlisted code drove output");

    property p_cfg_write;
        cfg_we && cfg_idx == '0 |=> term_code[0] == $past(cfg_code);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("code write not stored");

endmodule : oss_selector

`default_nettype wire

//--- shared/oss_pkg.sv
package oss_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int POS_W   = 32;
    localparam int SPD_W   = 16;
    localparam int CODE_W  = 8;

    // ------------------------------------------------------------
    // Assignment codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CONST_OFF    = 8'h80;
    localparam logic [7:0] CODE_ALARM_NO     = 8'h81;
    localparam logic [7:0] CODE_ALARM_NC     = 8'h82;
    localparam logic [7:0] CODE_READY        = 8'h84;
    localparam logic [7:0] CODE_PULSE_EN     = 8'h85;
    localparam logic [7:0] CODE_TORQUE_REC   = 8'h89;
    localparam logic [7:0] CODE_POS_DONE     = 8'h8a;
    localparam logic [7:0] CODE_SPEED_REACH  = 8'h8d;
    localparam logic [7:0] CODE_EXCITATION   = 8'h8e;
    localparam logic [7:0] CODE_HOME_DONE    = 8'h90;
    localparam logic [7:0] CODE_REPRESET     = 8'h95;
    localparam logic [7:0] CODE_WRAP_OVF     = 8'h98;
    localparam logic [7:0] CODE_FW_SOFT_LIM  = 8'h99;
    localparam logic [7:0] CODE_RV_SOFT_LIM  = 8'h9a;
    localparam logic [7:0] CODE_ONCE_PER_REV = 8'h9b;
    localparam logic [7:0] CODE_WRAP_ORIGIN  = 8'h9c;
    localparam logic [7:0] CODE_ANGLE_TICK   = 8'h9d;
    localparam logic [7:0] CODE_DATA_ZONE    = 8'h9f;
    localparam logic [7:0] CODE_ZONE_0       = 8'ha0;
    localparam logic [7:0] CODE_ZONE_7       = 8'ha7;
    localparam logic [7:0] CODE_BRAKE_REL    = 8'ha9;
    localparam logic [7:0] CODE_BOTH_STO     = 8'hac;
    localparam logic [7:0] CODE_ANY_STO      = 8'had;
    localparam logic [7:0] CODE_POS_REPORT   = 8'hb0;
    localparam logic [7:0] CODE_PULSE_REQ    = 8'hb1;

    // ------------------------------------------------------------
    // Reset values and angular figures
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_RESET      = CODE_CONST_OFF;
    localparam int         TICK_ANGLE_MDEG = 7200;
    localparam int         REV_ANGLE_MDEG  = 360000;
    localparam int         TICKS_PER_REV   = REV_ANGLE_MDEG / TICK_ANGLE_MDEG;
    localparam int         STEPS_PER_REV   = 10000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic alarm;
        logic ready;
        logic pulse_in_en;
        logic safe_torque_off_input_1;
        logic safe_torque_off_input_2;
        logic excited;
        logic pos_done;
        logic hs_home_done;
        logic home_done;
        logic preset_exec;
        logic preset_invalid;
        logic wrap_exceed;
        logic wrap_enable;
        logic brake_released;
        logic pos_report_bit;
        logic pulse_req_prep_done;
        logic step_fwd;
        logic step_rev;
    } oss_status_t;

    typedef struct packed {
        logic signed [POS_W-1:0] lo;
        logic signed [POS_W-1:0] hi;
    } oss_window_t;

endpackage : oss_pkg

//--- design/oss_window_cmp.sv
`timescale 1ns/100ps
`default_nettype none

module oss_window_cmp #(
    parameter int POS_W = 32
) (
    input  wire logic signed [POS_W-1:0] position,
    input  wire logic signed [POS_W-1:0] lo,
    input  wire logic signed [POS_W-1:0] hi,
    output logic                         in_zone
);

    // Bounds are inclusive; a reversed window never matches
    assign in_zone = (position >= lo) && (position <= hi);

endmodule : oss_window_cmp

`default_nettype wire

//--- design/oss_rev_counter.sv
`timescale 1ns/100ps
`default_nettype none

module oss_rev_counter #(
    parameter int MODULUS = 10000
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic step_fwd,
    input  wire logic step_rev,
    output logic      at_origin
);

    localparam int CNT_W = $clog2(MODULUS + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(MODULUS - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             at_origin;
    } oss_rev_state_t;

    oss_rev_state_t st_ff;
    oss_rev_state_t nxt_st;

    // ------------------------------------------------------------
    // Counting modulo one period
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            nxt_st.cnt = '0;
        end else if (step_fwd && !step_rev) begin
            nxt_st.cnt = (st_ff.cnt == LAST) ? '0 : st_ff.cnt + 1'b1;
        end else if (step_rev && !step_fwd) begin
            nxt_st.cnt = (st_ff.cnt == '0) ? LAST : st_ff.cnt - 1'b1;
        end
        nxt_st.at_origin = (nxt_st.cnt == '0);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{cnt: '0, at_origin: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign at_origin = st_ff.at_origin;

endmodule : oss_rev_counter

`default_nettype wire

//--- tb/oss_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Host side: reads the terminals when asked
// ------------------------------------------------------------
module oss_host_model #(
    parameter int NT = 6
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rd_req,
    input  wire logic [NT-1:0][7:0]    term_code,
    input  wire logic [NT-1:0]         term_out,
    input  wire logic                  wrap_tog,
    output logic                       rd_valid,
    output logic [8*NT+NT:0]           rd_data
);
    initial rd_valid = 1'b0;
    initial rd_data = '0;

    // Stale data is scrambled so nothing can match by accident
    always @(posedge ref_clk) begin
        rd_valid <= rd_req;
        if (rd_req) begin
            rd_data <= {wrap_tog, term_code, term_out};
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule : oss_host_model

`default_nettype wire

//--- tb/oss_selector_bench.sv
`timescale 1ns/100ps
`default_nettype none

module oss_selector_bench;
    localparam int NT   = 6;
    localparam int SPR  = 100;
    localparam int TMOD = SPR / 50;
    localparam int DW   = 8*NT+NT+1;
    localparam logic [7:0] TBL [36] = '{
        8'h80, 8'h81, 8'h82, 8'h84, 8'h85, 8'h89, 8'h8a, 8'h8d, 8'h8e,
        8'h90, 8'h95, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9f,
        8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9,
        8'hac, 8'had, 8'hb0, 8'hb1, 8'h83, 8'h86, 8'haa, 8'hb2, 8'hff};

    logic                          ref_clk  = 1'b0;
    logic                          resetn   = 1'b0;
    oss_pkg::oss_status_t          st       = '0;
    logic signed [31:0]            pos      = '0;
    logic signed [31:0]            fwl      = 32'sd100;
    logic signed [31:0]            rvl      = -32'sd100;
    logic signed [31:0]            wh       = '0;
    logic [15:0]                   spd_now  = '0;
    logic [15:0]                   spd_tgt  = '0;
    oss_pkg::oss_window_t          dz       = '0;
    oss_pkg::oss_window_t [7:0]    zn       = '0;
    logic                          cfg_we   = 1'b0;
    logic [2:0]                    cfg_idx  = '0;
    logic [7:0]                    cfg_code = '0;
    logic [NT-1:0][7:0]            term_code;
    logic [NT-1:0]                 term_out;
    logic                          wrap_tog;
    logic                          rd_req   = 1'b0;
    logic                          rd_valid;
    logic [DW-1:0]                 rd_data;
    logic [DW-1:0]                 notes[$];
    logic [NT-1:0][7:0]            codes    = {NT{8'h80}};
    logic                          tr_l     = 1'b1;
    logic                          home_l   = 1'b0;
    logic                          tog      = 1'b0;
    int                            rev      = 0;
    int                            tk       = 0;
    int                            fail_count  = 0;
    int                            comparisons = 0;
    int                            cycles      = 0;

    oss_selector #(.NUM_TERM(NT), .STEPS_PER_REV(SPR), .IDX_W(3)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .status_in(st),
        .position(pos), .speed_now(spd_now), .speed_target(spd_tgt),
        .fw_limit(fwl), .rv_limit(rvl), .wrap_home(wh),
        .data_zone(dz), .zones(zn), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
        .cfg_code(cfg_code), .term_code(term_code), .term_out(term_out),
        .wrap_overflow_toggle(wrap_tog));

    oss_host_model #(.NT(NT)) host (
        .ref_clk(ref_clk), .rd_req(rd_req), .term_code(term_code),
        .term_out(term_out), .wrap_tog(wrap_tog), .rd_valid(rd_valid),
        .rd_data(rd_data));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Expected terminal levels
    // ------------------------------------------------------------
    function automatic logic in_w(oss_pkg::oss_window_t w);
        return pos >= w.lo && pos <= w.hi;
    endfunction : in_w

    function automatic logic exp_bit(logic [7:0] c);
        case (c)
            8'h81: return st.alarm;
            8'h82: return !st.alarm;
            8'h84: return st.ready;
            8'h85: return st.pulse_in_en;
            8'h89: return tr_l;
            8'h8a: return st.pos_done;
            8'h8d: return spd_now == spd_tgt;
            8'h8e: return st.excited;
            8'h90: return home_l;
            8'h95: return st.preset_invalid;
            8'h98: return tog;
            8'h99: return pos >= fwl;
            8'h9a: return pos <= rvl;
            8'h9b: return rev == 0;
            8'h9c: return st.wrap_enable && pos == wh;
            8'h9d: return tk == 0;
            8'h9f: return in_w(dz);
            8'ha9: return st.brake_released;
            8'hac: return !st.safe_torque_off_input_1
                       && !st.safe_torque_off_input_2;
            8'had: return !st.safe_torque_off_input_1
                       || !st.safe_torque_off_input_2;
            8'hb0: return st.pos_report_bit;
            8'hb1: return st.pulse_req_prep_done;
            default: begin
                if (c >= 8'ha0 && c <= 8'ha7) return in_w(zn[c[2:0]]);
                return 1'b0;
            end
        endcase
    endfunction : exp_bit

    // ------------------------------------------------------------
    // Driver tasks
    // ------------------------------------------------------------
    task automatic check_now();
        logic [NT-1:0] e;
        for (int i = 0; i < NT; i++) e[i] = exp_bit(codes[i]);
        notes.push_back({tog, codes, e});
        rd_req <= 1'b1;
        @(posedge ref_clk);
        rd_req <= 1'b0;
    endtask : check_now

    // Rotating the table walks every code through every terminal
    task automatic set_codes(int g);
        fwl <= 32'($urandom_range(120));
        rvl <= 32'($urandom_range(120)) - 32'd120;
        wh  <= 32'($urandom_range(8)) - 32'd4;
        for (int i = 0; i <= NT; i++) begin
            cfg_we   <= 1'b1;
            cfg_idx  <= 3'(i);
            cfg_code <= (i < NT) ? TBL[(g + NT*i) % 36] : 8'h81;
            if (i < NT) codes[i] = TBL[(g + NT*i) % 36];
            @(posedge ref_clk);
        end
        cfg_we <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : set_codes

    task automatic apply();
        oss_pkg::oss_status_t s;
        logic off;
        s = oss_pkg::oss_status_t'(18'($urandom));
        // Steps beside a preset are ambiguous, so keep them apart
        s.step_fwd &= !s.preset_exec;
        s.step_rev &= !s.preset_exec;
        st      <= s;
        pos     <= $signed($urandom_range(240)) - 32'sd120;
        spd_now <= 16'($urandom_range(3));
        spd_tgt <= 16'($urandom_range(3));
        off = !s.safe_torque_off_input_1 || !s.safe_torque_off_input_2;
        tr_l = off ? 1'b1 : (s.excited ? 1'b0 : tr_l);
        if (s.preset_invalid) home_l = 1'b0;
        else if (s.hs_home_done || s.home_done || s.preset_exec) home_l = 1'b1;
        tog ^= s.wrap_exceed;
        if (s.preset_exec) begin
            rev = 0;
            tk  = 0;
        end else if (s.step_fwd != s.step_rev) begin
            rev = (rev + (s.step_fwd ? 1 : SPR-1)) % SPR;
            tk  = (tk + (s.step_fwd ? 1 : TMOD-1)) % TMOD;
        end
        @(posedge ref_clk);
        st.hs_home_done <= 1'b0;
        st.home_done    <= 1'b0;
        st.preset_exec  <= 1'b0;
        st.wrap_exceed  <= 1'b0;
        st.step_fwd     <= 1'b0;
        st.step_rev     <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check_now();
    endtask : apply

    // ------------------------------------------------------------
    // Result watcher and closing
    // ------------------------------------------------------------
    task automatic check(logic [DW-1:0] seen, logic [DW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t terminals got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("BAD %0t read without a note", $time);
            end else begin
                check(rd_data, notes.pop_front());
            end
        end
    end

    // Whole run is about 6100 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h3148));
        dz.lo = -32'sd10;
        dz.hi = 32'sd10;
        for (int k = 0; k < 8; k++) begin
            zn[k].lo = 32'(k*15);
            zn[k].hi = 32'(k*15+5);
        end
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check_now();
        for (int g = 0; g < 36; g++) begin
            set_codes(g);
            repeat (40) apply();
        end
        repeat (3) @(posedge ref_clk);
        give_verdict();
    end
endmodule : oss_selector_bench

`default_nettype wire
